// >>> logic/timer_pkg.sv
// Purpose: constants and carrier types of the capture/compare timer
// Assumes: AXI4-Lite register bus, 32-bit data, one clock
// Notes: offsets are byte addresses, registers sit in the low bits
// Summary of operation
// - Counter reaching modulo sets overflow flag
// - Overflow request only while its enable set
// - Capture or compare sets channel flag
// - Channel request only while channel enable one
// - Timer keeps running in wait mode
// - Registers unreachable during wait mode
// - Enabled request wakes from wait
// - Stop mode halts counting
// - Stop mode preserves registers and counter
// - Leaving stop resumes from preserved state
// - Counter halts during debug break
// - Clear-enable set lets break clears stick
// - Clear-enable zero protects flags during break
// - First clear step survives break, second clears
// - Seven prescaler rates chosen by three bits
package timer_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_COUNTER = 8'h04;
    localparam logic [7:0] OFF_MODULO = 8'h08;
    localparam logic [7:0] OFF_CH0_SC = 8'h0c;
    localparam logic [7:0] OFF_CH0_VAL = 8'h10;
    localparam logic [7:0] OFF_CH1_SC = 8'h14;
    localparam logic [7:0] OFF_CH1_VAL = 8'h18;
    localparam logic [7:0] OFF_BREAK_CTL = 8'h1c;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int STOP_BIT = 5;
    localparam int MODE_BIT = 4;
    localparam int EDGE_LSB = 2;
    localparam int PS_LSB = 0;
    localparam int BREAK_CLEAR_ENABLE_BIT = 0;
    localparam logic [15:0] MODULO_RST = 16'hffff;
    localparam logic [2:0] PS_MAX = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------------
    // State carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic compare;
        logic [1:0] edge_sel;
        logic [15:0] value;
        logic armed;
        logic pin_q;
        logic irq;
    } chan_t;
    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic stop;
        logic [2:0] prescale_select;
        logic [15:0] counter;
        logic [15:0] modulo;
        logic ovf_armed;
        logic break_clear_enable;
        logic ovf_irq;
        logic wake;
        chan_t [1:0] chan;
    } timer_state_t;
endpackage

// >>> logic/rate_prescaler.sv
// Purpose: divides the bus clock into one of seven counting rates
// Assumes: select codes 0..6 divide by 1..64, code 7 acts as 6
// Notes: tick is a flip-flop output, one cycle per period, held high every running cycle at divide-by-1
module rate_prescaler (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Control
    input wire logic i_run,
    input wire logic [2:0] i_select,
    // Rate pulse
    output logic o_tick
);
    logic [5:0] div_r;
    logic [5:0] mask;
    logic [2:0] sel;

    // Low divider bits, as many as the select code, all ones mark the end of a period
    always_comb begin
        sel = (i_select > timer_pkg::PS_MAX) ? timer_pkg::PS_MAX : i_select;
        mask = 6'(({6'h0, 1'b1} << sel) - 7'h1);
    end

    // Divider only advances while the timer runs
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            div_r <= 6'h0;
            o_tick <= 1'b0;
        end else begin
            div_r <= i_run ? div_r + 6'h1 : div_r;
            o_tick <= i_run && ((div_r & mask) == mask);
        end
    end
endmodule // rate_prescaler

// >>> logic/axil_port.sv
// Purpose: AXI4-Lite slave handshake for the timer registers
// Assumes: one write and one read outstanding at most
// Notes: write strobe is one cycle, read effect at the address edge
module axil_port (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // AXI4-Lite slave
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic i_rready,
    output logic o_rvalid,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Register side
    output logic o_wr_en,
    output logic [7:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic [3:0] o_wr_strb,
    input wire logic i_wr_err,
    output logic o_rd_en,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_err
);
    logic aw_got_r;
    logic w_got_r;

    assign o_wr_en = aw_got_r && w_got_r && !o_bvalid;
    assign o_rd_en = i_arvalid && o_arready;

    // Ready pulses last one cycle so an item is never taken twice
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            {o_awready, o_wready, o_arready, o_bvalid, o_rvalid} <= 5'h0;
            {aw_got_r, w_got_r} <= 2'h0;
            o_wr_addr <= 8'h0;
            o_wr_data <= 32'h0;
            o_wr_strb <= 4'h0;
            o_bresp <= 2'h0;
            o_rdata <= 32'h0;
            o_rresp <= 2'h0;
        end else begin
            o_awready <= i_awvalid && !o_awready && !aw_got_r && !o_bvalid;
            o_wready <= i_wvalid && !o_wready && !w_got_r && !o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_got_r <= 1'b1;
                o_wr_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_got_r <= 1'b1;
                o_wr_data <= i_wdata;
                o_wr_strb <= i_wstrb;
            end
            if (o_wr_en) begin
                {aw_got_r, w_got_r} <= 2'h0;
                o_bvalid <= 1'b1;
                o_bresp <= i_wr_err ? timer_pkg::RESP_SLVERR
                                    : timer_pkg::RESP_OKAY;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
            o_arready <= i_arvalid && !o_arready && !o_rvalid;
            if (o_rd_en) begin
                o_rvalid <= 1'b1;
                o_rdata <= i_rd_data;
                o_rresp <= i_rd_err ? timer_pkg::RESP_SLVERR
                                    : timer_pkg::RESP_OKAY;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule // axil_port

// >>> logic/capture_compare_timer.sv
// Purpose: two-channel timer with flags, requests, low-power, break
// Assumes: mode and break inputs synchronous to i_ref_clk
// Notes: flags clear by read-while-set then write zero
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
module capture_compare_timer (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // AXI4-Lite write
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // System state
    input wire logic i_wait_mode,
    input wire logic i_stop_mode,
    input wire logic i_break_active,
    // Capture inputs
    input wire logic [1:0] i_capture_pin,
    // Requests to the processor
    output logic o_overflow_irq,
    output logic [1:0] o_channel_irq,
    output logic o_wake_request
);
    timer_pkg::timer_state_t st_r;
    timer_pkg::timer_state_t st_nxt;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [31:0] rd_data;
    logic rd_err;
    logic tick;
    logic run;
    logic lock;
    logic clr_ok;
    logic [7:0] wb;
    logic [1:0] ch_evt;

    // ------------------------------------------------------------------
    // Bus slave and prescaler
    // ------------------------------------------------------------------
    axil_port u_port (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_rready(i_rready),
        .o_rvalid(o_rvalid),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_wr_en(wr_en),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb),
        .i_wr_err(wr_err),
        .o_rd_en(rd_en),
        .i_rd_data(rd_data),
        .i_rd_err(rd_err)
    );

    rate_prescaler u_presc (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(run),
        .i_select(st_r.prescale_select),
        .o_tick(tick)
    );

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Run only out of stop, out of break and not stopped by software;
    // wait mode is deliberately absent so the timer keeps going
    assign run = !st_r.stop && !i_stop_mode && !i_break_active;
    // Break with clear-enable low freezes every flag-clear step
    assign lock = i_break_active && !st_r.break_clear_enable;
    assign clr_ok = !lock;
    assign wb = wr_data[7:0];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        rd_data = 32'h0;
        rd_err = 1'b0;
        wr_err = 1'b0;
        ch_evt = 2'h0;
        // Read data and the first clear step
        unique case (i_araddr)
            timer_pkg::OFF_STATUS: rd_data[7:0] = {st_r.overflow_flag,
                st_r.overflow_irq_enable, st_r.stop, 2'h0,
                st_r.prescale_select};
            timer_pkg::OFF_COUNTER: rd_data[15:0] = st_r.counter;
            timer_pkg::OFF_MODULO: rd_data[15:0] = st_r.modulo;
            timer_pkg::OFF_CH0_SC, timer_pkg::OFF_CH1_SC: begin
                rd_data[7:0] = {st_r.chan[i_araddr[4]].flag,
                    st_r.chan[i_araddr[4]].irq_en, 1'b0,
                    st_r.chan[i_araddr[4]].compare,
                    st_r.chan[i_araddr[4]].edge_sel, 2'h0};
            end
            timer_pkg::OFF_CH0_VAL: rd_data[15:0] = st_r.chan[0].value;
            timer_pkg::OFF_CH1_VAL: rd_data[15:0] = st_r.chan[1].value;
            timer_pkg::OFF_BREAK_CTL: begin
                rd_data[timer_pkg::BREAK_CLEAR_ENABLE_BIT] = st_r.break_clear_enable;
            end
            default: rd_err = 1'b1;
        endcase
        // No register answers while the processor waits
        if (i_wait_mode) begin
            rd_data = 32'h0;
            rd_err = 1'b1;
        end
        if (rd_en && !rd_err && clr_ok) begin
            if (i_araddr == timer_pkg::OFF_STATUS && st_r.overflow_flag) begin
                st_nxt.ovf_armed = 1'b1;
            end
            if ((i_araddr == timer_pkg::OFF_CH0_SC ||
                 i_araddr == timer_pkg::OFF_CH1_SC) &&
                st_r.chan[i_araddr[4]].flag) begin
                st_nxt.chan[i_araddr[4]].armed = 1'b1;
            end
        end
        // Register writes and the second clear step
        if (wr_en && i_wait_mode) begin
            wr_err = 1'b1;
        end else if (wr_en) begin
            unique case (wr_addr)
                timer_pkg::OFF_STATUS: if (wr_strb[0]) begin
                    st_nxt.overflow_irq_enable = wb[timer_pkg::IRQ_EN_BIT];
                    st_nxt.stop = wb[timer_pkg::STOP_BIT];
                    st_nxt.prescale_select = wb[timer_pkg::PS_LSB +: 3];
                    // Armed state survives a locked break
                    if (!wb[timer_pkg::FLAG_BIT] && st_r.ovf_armed &&
                        clr_ok) begin
                        st_nxt.overflow_flag = 1'b0;
                        st_nxt.ovf_armed = 1'b0;
                    end
                end
                timer_pkg::OFF_COUNTER: st_nxt.counter = 16'h0;
                timer_pkg::OFF_MODULO: begin
                    st_nxt.modulo = merge16(st_r.modulo, wr_data, wr_strb);
                end
                timer_pkg::OFF_CH0_SC, timer_pkg::OFF_CH1_SC: begin
                    if (wr_strb[0]) begin
                        st_nxt.chan[wr_addr[4]].irq_en =
                            wb[timer_pkg::IRQ_EN_BIT];
                        st_nxt.chan[wr_addr[4]].compare =
                            wb[timer_pkg::MODE_BIT];
                        st_nxt.chan[wr_addr[4]].edge_sel =
                            wb[timer_pkg::EDGE_LSB +: 2];
                        if (!wb[timer_pkg::FLAG_BIT] &&
                            st_r.chan[wr_addr[4]].armed &&
                            clr_ok) begin
                            st_nxt.chan[wr_addr[4]].flag = 1'b0;
                            st_nxt.chan[wr_addr[4]].armed = 1'b0;
                        end
                    end
                end
                timer_pkg::OFF_CH0_VAL: begin
                    st_nxt.chan[0].value =
                        merge16(st_r.chan[0].value, wr_data, wr_strb);
                end
                timer_pkg::OFF_CH1_VAL: begin
                    st_nxt.chan[1].value =
                        merge16(st_r.chan[1].value, wr_data, wr_strb);
                end
                timer_pkg::OFF_BREAK_CTL: if (wr_strb[0]) begin
                    st_nxt.break_clear_enable = wb[timer_pkg::BREAK_CLEAR_ENABLE_BIT];
                end
                default: wr_err = 1'b1;
            endcase
        end
        // Counting after writes, so a new event beats a clear
        if (run && tick) begin
            if (st_nxt.counter == st_r.modulo) begin
                st_nxt.counter = 16'h0;
                st_nxt.overflow_flag = 1'b1;
                st_nxt.ovf_armed = 1'b0;
            end else begin
                st_nxt.counter = st_nxt.counter + 16'h1;
            end
        end
        // Per-channel capture and compare; stop mode freezes both
        for (int c = 0; c < 2; c++) begin
            st_nxt.chan[c].pin_q = i_capture_pin[c];
            if (st_r.chan[c].compare) begin
                ch_evt[c] = run && tick &&
                    st_r.counter == st_r.chan[c].value;
            end else begin
                ch_evt[c] = !i_stop_mode &&
                    ((st_r.chan[c].edge_sel[0] && i_capture_pin[c] &&
                      !st_r.chan[c].pin_q) ||
                     (st_r.chan[c].edge_sel[1] && !i_capture_pin[c] &&
                      st_r.chan[c].pin_q));
            end
            if (ch_evt[c]) begin
                if (!st_r.chan[c].compare) begin
                    st_nxt.chan[c].value = st_r.counter;
                end
                st_nxt.chan[c].flag = 1'b1;
                st_nxt.chan[c].armed = 1'b0;
            end
            st_nxt.chan[c].irq = st_nxt.chan[c].flag &&
                st_nxt.chan[c].irq_en;
        end
        st_nxt.ovf_irq = st_nxt.overflow_flag &&
            st_nxt.overflow_irq_enable;
        // Any enabled request pulls the part out of wait
        st_nxt.wake = i_wait_mode && (st_nxt.ovf_irq ||
            st_nxt.chan[0].irq || st_nxt.chan[1].irq);
    end

    // State register; a software stop before wait saves power
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_r <= '0;
            st_r.modulo <= timer_pkg::MODULO_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_overflow_irq = st_r.ovf_irq;
    assign o_channel_irq = {st_r.chan[1].irq, st_r.chan[0].irq};
    assign o_wake_request = st_r.wake;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    chk_ovf_set: assert property (
        (run && tick && st_r.counter == st_r.modulo && !wr_en)
        |=> st_r.overflow_flag && st_r.counter == 16'h0)
        else $error("overflow flag not set at modulo");
    chk_ovf_request: assert property (
        o_overflow_irq == (st_r.overflow_flag && st_r.overflow_irq_enable))
        else $error("overflow request differs from flag and enable");
    chk_chan_request: assert property (
        o_channel_irq == {st_r.chan[1].flag && st_r.chan[1].irq_en,
                          st_r.chan[0].flag && st_r.chan[0].irq_en})
        else $error("channel request differs from flag and enable");
    chk_chan_event: assert property (
        ch_evt[0] |=> st_r.chan[0].flag)
        else $error("channel event did not set its flag");
    chk_stop_freeze: assert property (
        (i_stop_mode && !wr_en) |=> $stable(st_r.counter)
        && $stable(st_r.chan[0].value) && !$rose(st_r.overflow_flag))
        else $error("timer changed in stop mode");
    chk_break_halt: assert property (
        (i_break_active && !wr_en) |=> $stable(st_r.counter))
        else $error("counter moved during break");
    chk_break_protect: assert property (
        lock |=> !$fell(st_r.overflow_flag) && !$fell(st_r.chan[0].flag))
        else $error("flag cleared during protected break");
    chk_arm_survive: assert property (
        (lock && st_r.ovf_armed && !(run && tick)) |=> st_r.ovf_armed)
        else $error("first clear step lost in break");
    chk_wait_locked: assert property (
        (wr_en && i_wait_mode) |=> $stable(st_r.modulo)
        && $stable(st_r.overflow_irq_enable))
        else $error("register written during wait");
    chk_wait_wake: assert property (
        (i_wait_mode && o_overflow_irq) |=> o_wake_request)
        else $error("enabled request did not wake");
    chk_clear_order: assert property (
        $fell(st_r.overflow_flag) |-> $past(st_r.ovf_armed))
        else $error("flag cleared without prior read");

    cov_overflow_irq: cover property (run && tick ##1 o_overflow_irq);
    cov_capture: cover property (ch_evt[0] && !st_r.chan[0].compare);
    cov_break_clear: cover property (i_break_active &&
        st_r.break_clear_enable ##1 $fell(st_r.overflow_flag));
    cov_wake: cover property ($rose(o_wake_request));
endmodule // capture_compare_timer

// >>> verification/core_model.sv
// Purpose: processor core model, master side of the register bus
// Assumes: slave answers in its own time; bench timeout ends a hang
// Notes: signals change by non-blocking assignment after an edge
module core_model (
    // Clock
    input wire logic i_ref_clk,
    // Write channels
    output logic o_awvalid,
    input wire logic i_awready,
    output logic [7:0] o_awaddr,
    output logic o_wvalid,
    input wire logic i_wready,
    output logic [31:0] o_wdata,
    output logic [3:0] o_wstrb,
    input wire logic i_bvalid,
    output logic o_bready,
    input wire logic [1:0] i_bresp,
    // Read channels
    output logic o_arvalid,
    input wire logic i_arready,
    output logic [7:0] o_araddr,
    input wire logic i_rvalid,
    output logic o_rready,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus from time zero; full byte strobes on every write
    initial begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
        {o_awaddr, o_araddr, o_wdata} = 48'h0;
        o_wstrb = 4'hf;
    end
    // Write: address and data offered together, each dropped once taken;
    // released payload is inverted so stale values cannot pass for new
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge i_ref_clk);
        {o_awaddr, o_wdata} <= {a, d};
        {o_awvalid, o_wvalid, o_bready} <= 3'h7;
        do begin
            @(posedge i_ref_clk);
            if (i_awready) begin
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;
            end
            if (i_wready) begin
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
        end while (!i_bvalid);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask
    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge i_ref_clk);
        o_araddr <= a;
        {o_arvalid, o_rready} <= 2'h3;
        do begin
            @(posedge i_ref_clk);
            if (i_arready) begin
                o_arvalid <= 1'b0;
                o_araddr <= ~a;
            end
        end while (!i_rvalid);
        {d, r} = {i_rdata, i_rresp};
        o_rready <= 1'b0;
    endtask
endmodule // core_model

// >>> verification/test_timer_irq_lowpower_break.sv
// Purpose: self-checking bench for the capture/compare timer
// Assumes: 10 MHz clock, synchronous active-high reset
// Notes: counter runs at divide-by-1 so events come within tens of cycles
module test_timer_irq_lowpower_break;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, sys_rst = 1'b1;
    logic wait_mode = 1'b0, stop_mode = 1'b0, break_active = 1'b0;
    logic [1:0] cap_pin = 2'h0, chan_irq, bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, ovf_irq, wake;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_val;
    logic [3:0] wstrb;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    capture_compare_timer i_dut (
        .i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .i_wait_mode(wait_mode),
        .i_stop_mode(stop_mode), .i_break_active(break_active),
        .i_capture_pin(cap_pin), .o_overflow_irq(ovf_irq),
        .o_channel_irq(chan_irq), .o_wake_request(wake));
    core_model i_core (
        .i_ref_clk(ref_clk), .o_awvalid(awvalid), .i_awready(awready),
        .o_awaddr(awaddr), .o_wvalid(wvalid), .i_wready(wready),
        .o_wdata(wdata), .o_wstrb(wstrb), .i_bvalid(bvalid),
        .o_bready(bready), .i_bresp(bresp), .o_arvalid(arvalid),
        .i_arready(arready), .o_araddr(araddr), .i_rvalid(rvalid),
        .o_rready(rready), .i_rdata(rdata), .i_rresp(rresp));
    // Clock, and a cycle ceiling well above the few hundred cycles needed
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_core.wr(a, d, resp);
    endtask
    task automatic rd(input logic [7:0] a);
        i_core.rd(a, rd_val, resp);
    endtask
    // One capture edge on channel 0
    task automatic pulse();
        @(posedge ref_clk) cap_pin <= 2'h1;
        repeat (2) @(posedge ref_clk);
        cap_pin <= 2'h0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_reset();
        rd(timer_pkg::OFF_MODULO);
        chk("modulo", rd_val, {16'h0, timer_pkg::MODULO_RST});
        rd(timer_pkg::OFF_BREAK_CTL);
        chk("clear enable", rd_val, 32'h0);
        rd(8'h20);
        chk("unmapped", {30'h0, resp}, {30'h0, timer_pkg::RESP_SLVERR});
        wr(timer_pkg::OFF_STATUS, {29'h0, timer_pkg::PS_MAX});
        rd(timer_pkg::OFF_STATUS);
        chk("prescale", rd_val, {29'h0, timer_pkg::PS_MAX});
    endtask
    task automatic t_overflow();
        wr(timer_pkg::OFF_STATUS, 32'h0);
        wr(timer_pkg::OFF_COUNTER, 32'h0);
        wr(timer_pkg::OFF_MODULO, 32'h10);
        repeat (40) @(posedge ref_clk);
        chk("masked ovf", {31'h0, ovf_irq}, 32'h0);
        rd(timer_pkg::OFF_STATUS);
        chk("ovf flag", rd_val, 32'h80);
        wr(timer_pkg::OFF_STATUS, 32'hc0);
        chk("ovf irq", {31'h0, ovf_irq}, 32'h1);
        wr(timer_pkg::OFF_STATUS, 32'he0);
        rd(timer_pkg::OFF_STATUS);
        chk("stopped", rd_val, 32'he0);
        wr(timer_pkg::OFF_STATUS, 32'h60);
        chk("ovf cleared", {31'h0, ovf_irq}, 32'h0);
    endtask
    task automatic t_wait();
        wr(timer_pkg::OFF_STATUS, 32'h40);
        @(posedge ref_clk) wait_mode <= 1'b1;
        wr(timer_pkg::OFF_MODULO, 32'h5);
        chk("wait write", {30'h0, resp}, 32'h2);
        for (int k = 0; k < 60 && !wake; k++) @(posedge ref_clk);
        chk("wake", {31'h0, wake}, 32'h1);
        @(posedge ref_clk) wait_mode <= 1'b0;
        rd(timer_pkg::OFF_MODULO);
        chk("modulo kept", rd_val, 32'h10);
    endtask
    // Stop mode or break must hold the counter and resume it afterwards
    task automatic t_freeze(input logic brk);
        logic [31:0] first;
        wr(timer_pkg::OFF_STATUS, 32'h0);
        @(posedge ref_clk) {break_active, stop_mode} <= {brk, !brk};
        repeat (2) @(posedge ref_clk);
        rd(timer_pkg::OFF_COUNTER);
        first = rd_val;
        repeat (20) @(posedge ref_clk);
        rd(timer_pkg::OFF_COUNTER);
        chk("held count", rd_val, first);
        rd(timer_pkg::OFF_MODULO);
        chk("modulo", rd_val, 32'h10);
        @(posedge ref_clk) {break_active, stop_mode} <= 2'h0;
        rd(timer_pkg::OFF_COUNTER);
        chk("resumed", {31'h0, rd_val != first}, 32'h1);
    endtask
    task automatic t_channel();
        wr(timer_pkg::OFF_CH1_VAL, 32'h5);
        wr(timer_pkg::OFF_CH1_SC, 32'h50);
        for (int k = 0; k < 60 && !chan_irq[1]; k++) @(posedge ref_clk);
        chk("compare irq", {30'h0, chan_irq}, 32'h2);
        wr(timer_pkg::OFF_CH1_SC, 32'h80);
        chk("ch1 masked", {30'h0, chan_irq}, 32'h0);
        wr(timer_pkg::OFF_CH0_SC, 32'h44);
        pulse();
        chk("capture irq", {30'h0, chan_irq}, 32'h1);
        rd(timer_pkg::OFF_CH0_SC);
        @(posedge ref_clk) break_active <= 1'b1;
        wr(timer_pkg::OFF_CH0_SC, 32'h44);
        chk("break held", {31'h0, chan_irq[0]}, 32'h1);
        @(posedge ref_clk) break_active <= 1'b0;
        wr(timer_pkg::OFF_CH0_SC, 32'h44);
        chk("late clear", {31'h0, chan_irq[0]}, 32'h0);
        wr(timer_pkg::OFF_BREAK_CTL, 32'h1);
        pulse();
        @(posedge ref_clk) break_active <= 1'b1;
        rd(timer_pkg::OFF_CH0_SC);
        wr(timer_pkg::OFF_CH0_SC, 32'h44);
        @(posedge ref_clk) break_active <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("break clear", {31'h0, chan_irq[0]}, 32'h0);
    endtask
    // Main sequence after the 20-cycle reset
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_overflow();
        t_wait();
        t_freeze(1'b0);
        t_freeze(1'b1);
        t_channel();
        close_out();
    end
endmodule // test_timer_irq_lowpower_break
